/* core/ves_defs.svh */
// Constants of the vectored exception sequencer: bus addresses, status
// codes, vectors, status word fields. Included by the core, bus model and bench.
//
// Notes on behaviour
// (RQ1) Vectored mode: master acknowledge cycle, vector from low data byte.
// (RQ2) Return: master end-of-interrupt read; top bit zero ends the sequence.
// (RQ3) Uncascaded master gives only vectors 0..127; negative means cascade.
// (RQ4) Only the master controller drives the maskable request pin.
// (RQ5) After cascade address, cascaded acknowledge; vector unsigned 0..255.
// (RQ6) Cascaded return: look up cascade address, cascaded EOI, discard byte.
// (RQ7) Every falling edge of the non-maskable pin raises an interrupt.
// (RQ8) Non-maskable: read FFFF00 with code 0100, discard, vector 1.
// (RQ9) Return from trap runs no end-of-interrupt cycles.
// (RQ10) Non-trace traps return to the first byte of the trapping instruction.
// (RQ11) Trap entry leaves the interrupt enable bit untouched.
// (RQ12) At a boundary: non-maskable, maskable, trace pending, else execute.
// (RQ13) Per instruction at most one interrupt and one of seven traps.
// (RQ14) Interrupt entry at a boundary or an interruptible point.
// (RQ15) Unfinished string op: clear trace pending, return to its first byte.
// (RQ16) Interrupt entry copies the status word, clears S, U, T, P and I.
// (RQ17) Non-vectored: read FFFE00 with code 0100, discard, vector 0.
// (RQ18) Vectored: read FFFE00 with code 0100; non-negative byte is vector.
// (RQ19) Byte -16..-1: cascade address at base+4*byte, read with code 0101.
// (RQ20) Non-trace trap first restores stack pointer and status word.
// (RQ21) Vectors: slave 3, priv 4, call 5, div 6, flag 7, bkpt 8, undef 10.
// (RQ22) Privileged operation with user bit set raises privilege violation.
// (RQ23) Maskable request is a level, taken only while enable bit is set.
// (RQ24) Configuration bit one selects vectored, zero non-vectored handling.
// (RQ25) Descriptor fetched as 32 bits at vector*4 plus table base.
`ifndef VES_DEFS_SVH
`define VES_DEFS_SVH
`define VES_ADR_ACK_NMI 24'hFFFF00
`define VES_ADR_ACK_INT 24'hFFFE00
`define VES_SC_ACK_M    4'h4
`define VES_SC_ACK_C    4'h5
`define VES_SC_EOI_M    4'h6
`define VES_SC_EOI_C    4'h7
`define VES_SC_MEM      4'hA
`define VES_VEC_NVI     8'h00
`define VES_VEC_NMI     8'h01
`define VES_VEC_SLAVE   8'h03
`define VES_VEC_PRIV    8'h04
`define VES_VEC_CALL    8'h05
`define VES_VEC_DIVZ    8'h06
`define VES_VEC_FLAG    8'h07
`define VES_VEC_BKPT    8'h08
`define VES_VEC_TRACE   8'h09
`define VES_VEC_UNDEF   8'h0A
`define VES_CAS_MIN     8'hF0
`define VES_PSR_RST     16'h0000
`define VES_PSR_T       1
`define VES_PSR_U       8
`define VES_PSR_P       10
`define VES_PSR_I       11
`define VES_CLR_INT     16'h0F02
`define VES_CLR_TRAP    16'h0702
`define VES_MSK_P       16'h0400
`endif

/* core/ves_pkg.sv */
// Types of the vectored exception sequencer.
// Assumes the constants header sits beside it.
package ves_pkg;
  typedef enum logic [2:0] {
    VES_TK_SLAVE, VES_TK_CALL, VES_TK_DIVZ, VES_TK_FLAG, VES_TK_BKPT,
    VES_TK_UNDEF
  } ves_trap_t;
  typedef enum logic [1:0] {
    VES_KD_NMI, VES_KD_INT, VES_KD_TRACE, VES_KD_TRAP
  } ves_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACKM, ST_CTAB, ST_CACK, ST_DESC, ST_EOIM, ST_ETAB, ST_EOIC
  } ves_state_t;
endpackage

/* core/ves_sequencer.sv */
// Exception recognition, vector acquisition and end-of-interrupt cycles.
// Assumes a bus unit that runs one read per held request and answers with
// a one-cycle done pulse, and a core that signals instruction boundaries.
`include "ves_defs.svh"
module ves_sequencer (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              nmi_pin_b,
  input  wire logic              int_pin_b,
  input  wire logic              cfg_vectored,
  input  wire logic [31:0]       dispatch_table_base,
  input  wire logic              inst_start,
  input  wire logic              bnd_ok,
  input  wire logic              string_unfinished,
  input  wire logic [23:0]       cur_pc,
  input  wire logic [23:0]       next_pc,
  input  wire logic              trap_req,
  input  wire ves_pkg::ves_trap_t trap_kind,
  input  wire logic              priv_op,
  input  wire logic              return_from_interrupt_op_req,
  input  wire logic              return_from_trap_op_req,
  input  wire logic              psr_wr,
  input  wire logic [15:0]       psr_wr_val,
  input  wire logic              bus_done,
  input  wire logic [31:0]       bus_rdata,
  output logic                   bus_req,
  output logic [23:0]            bus_addr,
  output logic [3:0]             bus_status,
  output logic                   bus_dword,
  output logic                   exec_go,
  output logic                   svc_go,
  output ves_pkg::ves_kind_t     svc_kind,
  output logic [7:0]             svc_vector,
  output logic [31:0]            svc_desc,
  output logic [23:0]            svc_ret_addr,
  output logic [15:0]            psr_copy,
  output logic [15:0]            psr_q,
  output logic                   sp_restore,
  output logic                   busy
);
  import ves_pkg::*;

  ves_state_t  st_r;
  ves_kind_t   kind_r;
  logic        int_s1_r, int_s2_r, nmi_s1_r, nmi_s2_r, nmi_s3_r;
  logic        nmi_pend_r;
  logic [15:0] psr_r, psr_start_r;
  logic [7:0]  vec_r;
  logic        idle, take_trap, take_nmi, take_int, take_trace, take_go;
  logic [7:0]  trap_vec;
  logic [31:0] tab_addr, desc_addr;
  // One clock and one reset for every assertion of this module
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  //----------------------------------------------------------------
  // Pin synchronisers and non-maskable edge capture
  //----------------------------------------------------------------
  // Two flops on the maskable pin, three on the non-maskable; the edge detector looks only at later stages
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_s1_r <= 1'b1;
      int_s2_r <= 1'b1;
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      nmi_s3_r <= 1'b1;
    end else begin
      int_s1_r <= int_pin_b;
      int_s2_r <= int_s1_r;
      nmi_s1_r <= nmi_pin_b;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
    end
  end

  // Pending flag: a new edge in the taking cycle wins over the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_s3_r && !nmi_s2_r) begin
      nmi_pend_r <= 1'b1; // [RQ7]
    end else if (take_nmi) begin
      nmi_pend_r <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Recognition at the boundary
  //----------------------------------------------------------------
  // A trap ends the instruction, so it outranks a boundary in the same cycle
  always_comb begin
    idle      = (st_r == ST_IDLE);
    take_trap = idle && (trap_req || (priv_op && psr_r[`VES_PSR_U])); // [RQ22]
    take_nmi  = idle && !take_trap && bnd_ok && nmi_pend_r; // [RQ12] [RQ14]
    take_int  = idle && !take_trap && bnd_ok && !nmi_pend_r &&
                !int_s2_r && psr_r[`VES_PSR_I]; // [RQ23]
    take_trace = idle && !take_trap && bnd_ok && !nmi_pend_r && // [RQ12]
                 !(!int_s2_r && psr_r[`VES_PSR_I]) && psr_r[`VES_PSR_P];
    take_go   = idle && !take_trap && bnd_ok && !take_nmi && !take_int &&
                !take_trace;
  end

  // Trap vector table; privilege violation outranks a reported kind
  always_comb begin
    trap_vec = `VES_VEC_UNDEF;
    if (priv_op && psr_r[`VES_PSR_U]) begin
      trap_vec = `VES_VEC_PRIV; // [RQ21]
    end else begin
      unique case (trap_kind)
        VES_TK_SLAVE: trap_vec = `VES_VEC_SLAVE;
        VES_TK_CALL:  trap_vec = `VES_VEC_CALL;
        VES_TK_DIVZ:  trap_vec = `VES_VEC_DIVZ;
        VES_TK_FLAG:  trap_vec = `VES_VEC_FLAG;
        VES_TK_BKPT:  trap_vec = `VES_VEC_BKPT;
        VES_TK_UNDEF: trap_vec = `VES_VEC_UNDEF;
        default:      trap_vec = `VES_VEC_UNDEF;
      endcase
    end
  end

  // Cascade entry sits below the base: sign-extended byte times four
  always_comb begin
    tab_addr  = dispatch_table_base +
                {{22{bus_rdata[7]}}, bus_rdata[7:0], 2'b00}; // [RQ19] [RQ6]
    desc_addr = dispatch_table_base + {22'h0, vec_r, 2'b00}; // [RQ25]
  end

  //----------------------------------------------------------------
  // Status word
  //----------------------------------------------------------------
  // Core writes lose to entry; start value kept for trap restore
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      psr_r       <= `VES_PSR_RST;
      psr_start_r <= `VES_PSR_RST;
      psr_copy    <= `VES_PSR_RST;
    end else if (take_trap) begin
      psr_copy <= psr_start_r; // [RQ20]
      psr_r    <= psr_start_r & ~`VES_CLR_TRAP; // [RQ11]
    end else if (take_nmi || take_int) begin
      psr_copy <= string_unfinished ? (psr_r & ~`VES_MSK_P) : psr_r;
      psr_r    <= psr_r & ~`VES_CLR_INT; // [RQ16] [RQ15]
    end else if (take_trace) begin
      psr_copy <= psr_r & ~`VES_MSK_P;
      psr_r    <= psr_r & ~`VES_CLR_TRAP;
    end else if (psr_wr) begin
      psr_r <= psr_wr_val;
    end else if (inst_start) begin
      psr_r[`VES_PSR_P] <= psr_r[`VES_PSR_T];
      psr_start_r       <= {psr_r[15:11], psr_r[`VES_PSR_T], psr_r[9:0]};
    end
  end

  //----------------------------------------------------------------
  // Sequencer and bus requests
  //----------------------------------------------------------------
  // One read at a time; the request stands until the done pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r         <= ST_IDLE;
      kind_r       <= VES_KD_INT;
      vec_r        <= 8'h00;
      bus_req      <= 1'b0;
      bus_addr     <= 24'h000000;
      bus_status   <= 4'h0;
      bus_dword    <= 1'b0;
      exec_go      <= 1'b0;
      svc_go       <= 1'b0;
      svc_desc     <= 32'h00000000;
      svc_ret_addr <= 24'h000000;
      sp_restore   <= 1'b0;
    end else begin
      exec_go    <= take_go;
      svc_go     <= 1'b0;
      sp_restore <= take_trap;
      unique case (st_r)
        ST_IDLE: begin
          if (take_trap) begin
            kind_r       <= VES_KD_TRAP;
            vec_r        <= trap_vec;
            svc_ret_addr <= cur_pc; // [RQ10]
            st_r         <= ST_DESC;
          end else if (take_nmi || take_int) begin
            kind_r       <= take_nmi ? VES_KD_NMI : VES_KD_INT;
            svc_ret_addr <= string_unfinished ? cur_pc : next_pc; // [RQ15]
            bus_req      <= 1'b1;
            bus_dword    <= 1'b0;
            bus_status   <= `VES_SC_ACK_M; // [RQ1]
            bus_addr     <= take_nmi ? `VES_ADR_ACK_NMI
                                     : `VES_ADR_ACK_INT; // [RQ8] [RQ17]
            st_r         <= ST_ACKM;
          end else if (take_trace) begin
            kind_r       <= VES_KD_TRACE;
            vec_r        <= `VES_VEC_TRACE;
            svc_ret_addr <= next_pc;
            st_r         <= ST_DESC;
          end else if (return_from_interrupt_op_req) begin
            bus_req    <= 1'b1;
            bus_dword  <= 1'b0;
            bus_status <= `VES_SC_EOI_M;
            bus_addr   <= `VES_ADR_ACK_INT;
            st_r       <= ST_EOIM;
          end
        end
        ST_ACKM: begin
          if (bus_done) begin
            bus_req <= 1'b0;
            if (kind_r == VES_KD_NMI) begin
              vec_r <= `VES_VEC_NMI; // [RQ8]
              st_r  <= ST_DESC;
            end else if (!cfg_vectored) begin
              vec_r <= `VES_VEC_NVI; // [RQ24] [RQ17]
              st_r  <= ST_DESC;
            end else if (!bus_rdata[7]) begin
              vec_r <= bus_rdata[7:0]; // [RQ18] [RQ3]
              st_r  <= ST_DESC;
            end else if (bus_rdata[7:0] >= `VES_CAS_MIN) begin
              bus_req    <= 1'b1;
              bus_dword  <= 1'b1;
              bus_status <= `VES_SC_MEM;
              bus_addr   <= tab_addr[23:0]; // [RQ19]
              st_r       <= ST_CTAB;
            end else begin
              // Reserved negative value: fall back to the default vector
              vec_r <= `VES_VEC_NVI;
              st_r  <= ST_DESC;
            end
          end
        end
        ST_CTAB: begin
          if (bus_done) begin
            bus_dword  <= 1'b0;
            bus_status <= `VES_SC_ACK_C; // [RQ19]
            bus_addr   <= bus_rdata[23:0];
            st_r       <= ST_CACK;
          end
        end
        ST_CACK: begin
          if (bus_done) begin
            bus_req <= 1'b0;
            vec_r   <= bus_rdata[7:0]; // [RQ5]
            st_r    <= ST_DESC;
          end
        end
        ST_DESC: begin
          // Descriptor read; request raised on entry, dropped at done
          if (!bus_req) begin
            bus_req    <= 1'b1;
            bus_dword  <= 1'b1;
            bus_status <= `VES_SC_MEM;
            bus_addr   <= desc_addr[23:0]; // [RQ25]
          end else if (bus_done) begin
            bus_req  <= 1'b0;
            svc_desc <= bus_rdata;
            svc_go   <= 1'b1; // [RQ13]
            st_r     <= ST_IDLE;
          end
        end
        ST_EOIM: begin
          if (bus_done) begin
            if (!bus_rdata[7]) begin
              bus_req <= 1'b0; // [RQ2]
              st_r    <= ST_IDLE;
            end else begin
              bus_dword  <= 1'b1;
              bus_status <= `VES_SC_MEM;
              bus_addr   <= tab_addr[23:0]; // [RQ6]
              st_r       <= ST_ETAB;
            end
          end
        end
        ST_ETAB: begin
          if (bus_done) begin
            bus_dword  <= 1'b0;
            bus_status <= `VES_SC_EOI_C;
            bus_addr   <= bus_rdata[23:0];
            st_r       <= ST_EOIC;
          end
        end
        ST_EOIC: begin
          if (bus_done) begin
            bus_req <= 1'b0; // Byte read back is dropped [RQ6]
            st_r    <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Visible copies of internal state; return_from_trap_op needs nothing here [RQ9]
  always_comb begin
    svc_kind   = kind_r;
    svc_vector = vec_r;
    psr_q      = psr_r;
    busy       = (st_r != ST_IDLE);
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  chk_nmi_vector: assert property ( // [RQ8]
    svc_go && kind_r == VES_KD_NMI |-> vec_r == 8'h01)
    else $error("nmi vector not one");
  chk_ack_cycle: assert property ( // [RQ18]
    st_r == ST_ACKM |-> bus_status == 4'h4 &&
    (bus_addr == 24'hFFFE00 || bus_addr == 24'hFFFF00))
    else $error("bad acknowledge cycle");
  chk_cas_status: assert property ( // [RQ19]
    st_r == ST_CACK |-> bus_status == 4'h5 && !bus_dword)
    else $error("bad cascaded status");
  chk_eoi_stop: assert property ( // [RQ2]
    st_r == ST_EOIM && bus_done && !bus_rdata[7] |=> idle && !bus_req)
    else $error("eoi continued");
  chk_return_from_trap_op_quiet: assert property ( // [RQ9]
    idle && return_from_trap_op_req && !return_from_interrupt_op_req && !take_nmi && !take_int &&
    !take_trap && !take_trace |=> !bus_req)
    else $error("return_from_trap_op made a bus cycle");
  chk_trap_ienable: assert property ( // [RQ11]
    take_trap |=> psr_r[`VES_PSR_I] == $past(psr_start_r[`VES_PSR_I]))
    else $error("trap changed enable");
  chk_nmi_edge: assert property ( // [RQ7]
    nmi_s3_r && !nmi_s2_r |=> nmi_pend_r)
    else $error("nmi edge lost");
  chk_int_clear: assert property ( // [RQ16]
    take_int |=> !psr_r[`VES_PSR_I] && !psr_r[`VES_PSR_U])
    else $error("entry left bits set");
  chk_nv_vector: assert property ( // [RQ17]
    st_r == ST_ACKM && bus_done && kind_r == VES_KD_INT && !cfg_vectored
    |=> vec_r == 8'h00 ##[1:300] svc_go)
    else $error("non-vectored vector wrong");

  cov_cascade: cover property (st_r == ST_CACK && bus_done);
  cov_eoi_casc: cover property (st_r == ST_EOIC && bus_done);
  cov_trace: cover property (take_trace);
  cov_trap: cover property (take_trap ##[1:50] svc_go);
endmodule

/* verification/ves_bus_model.sv */
// Controllers and memory behind the sequencer read bus.
// Assumes a read is held until the edge at which done is seen.
`include "ves_defs.svh"
module ves_bus_model (
  input  wire logic        clk_sys,
  input  wire logic        bus_req,
  input  wire logic [23:0] bus_addr,
  input  wire logic [3:0]  bus_status,
  input  wire logic        slow,
  input  wire logic [7:0]  ack_byte,
  input  wire logic [7:0]  cas_byte,
  input  wire logic [7:0]  eoi_byte,
  output logic             bus_done,
  output logic [31:0]      bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] junk_r = 24'h5A5A5A;
  // ----
  // Answer each read once, at once or after a stall
  // ----
  initial begin
    bus_done = 1'b0;
    bus_rdata = 32'h0;
    forever begin
      @(negedge clk_sys);
      // Idle data moves each cycle so a stale byte never passes
      junk_r = junk_r + 24'h010203;
      bus_rdata = {junk_r[7:0], junk_r};
      if (bus_req === 1'b1) begin
        repeat (slow ? 3 : 0) @(negedge clk_sys);
        case (bus_status)
          `VES_SC_ACK_M: bus_rdata = {junk_r, ack_byte};
          `VES_SC_ACK_C: bus_rdata = {junk_r, cas_byte};
          `VES_SC_EOI_M: bus_rdata = {junk_r, eoi_byte};
          `VES_SC_EOI_C: bus_rdata = {junk_r, ~junk_r[7:0]};
          default: bus_rdata = {8'hC5, bus_addr ^ 24'h00F0F0};
        endcase
        bus_done = 1'b1;
        @(negedge clk_sys);
        bus_done = 1'b0;
      end
    end
  end
endmodule

/* verification/ves_sequencer_tb.sv */
// Bench of the exception sequencer: interrupts, returns and traps.
// Assumes the bus model answers every read the sequencer makes.
`include "ves_defs.svh"
module ves_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ves_pkg::*;
  // ----
  // Signals
  // ----
  logic        clk_sys = 0, rst_b = 0, nmi_pin_b = 1, int_pin_b = 1;
  logic        cfg_vectored = 1, inst_start = 0, bnd_ok = 0;
  logic [31:0] dispatch_table_base = 32'h0000_4000;
  logic        string_unfinished = 0, trap_req = 0, priv_op = 0;
  logic [23:0] cur_pc = 24'h001000, next_pc = 24'h001006;
  logic        return_from_interrupt_op_req = 0, return_from_trap_op_req = 0, psr_wr = 0, slow = 0;
  ves_trap_t   trap_kind = VES_TK_SLAVE;
  logic [15:0] psr_wr_val = 16'h0000, psr_copy, psr_q;
  logic        bus_done, bus_req, bus_dword, exec_go, svc_go;
  logic        sp_restore, busy;
  logic [31:0] bus_rdata, svc_desc, lfsr_r = 32'hC637B023;
  logic [23:0] bus_addr, svc_ret_addr;
  logic [3:0]  bus_status;
  ves_kind_t   svc_kind;
  logic [7:0]  svc_vector, ack_byte = 0, cas_byte = 0, eoi_byte = 0, b;
  logic [7:0]  cb[5] = '{8'hA5, 8'h7F, 8'hF0, 8'hFF, 8'h80};
  logic [7:0]  tv[7] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h04};
  logic [28:0] exp_q[$], got_q[$];
  int          num_errors = 0, total_checks = 0;

  ves_sequencer dut (.clk_sys, .rst_b, .nmi_pin_b, .int_pin_b,
    .cfg_vectored, .dispatch_table_base, .inst_start, .bnd_ok,
    .string_unfinished, .cur_pc, .next_pc, .trap_req, .trap_kind,
    .priv_op, .return_from_interrupt_op_req, .return_from_trap_op_req, .psr_wr, .psr_wr_val, .bus_done,
    .bus_rdata, .bus_req, .bus_addr, .bus_status, .bus_dword, .exec_go,
    .svc_go, .svc_kind, .svc_vector, .svc_desc, .svc_ret_addr,
    .psr_copy, .psr_q, .sp_restore, .busy);
  ves_bus_model u_bus (.clk_sys, .bus_req, .bus_addr, .bus_status, .slow,
    .ack_byte, .cas_byte, .eoi_byte, .bus_done, .bus_rdata);

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // Every completed read enters the log
  always @(posedge clk_sys) begin
    if (bus_req === 1'b1 && bus_done === 1'b1) begin
      got_q.push_back({bus_dword, bus_status, bus_addr});
    end
  end
  // ----
  // Expectations and helpers
  // ----
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h0);
  endfunction
  // Cascade entry: signed index below the table base
  function automatic logic [23:0] tab(input logic [7:0] c);
    return 24'(dispatch_table_base + {{24{c[7]}}, c} * 4);
  endfunction
  function automatic logic [23:0] cad(input logic [7:0] c);
    return tab(c) ^ 24'h00F0F0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic exp_rd(input logic [3:0] st, input logic [23:0] a);
    exp_q.push_back({st == `VES_SC_MEM, st, a});
  endtask
  task automatic cmp_rd();
    chk("read count", exp_q.size(), got_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      chk("read", exp_q.pop_front(), got_q.pop_front());
    end
    exp_q.delete();
    got_q.delete();
  endtask
  task automatic bnd_pulse();
    @(negedge clk_sys);
    bnd_ok = 1;
    @(negedge clk_sys);
    bnd_ok = 0;
  endtask
  task automatic set_psr(input logic [15:0] p);
    @(negedge clk_sys);
    psr_wr = 1;
    psr_wr_val = p;
    @(negedge clk_sys);
    psr_wr = 0;
  endtask
  task automatic wait_idle();
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys);
    chk("busy", 0, busy);
  endtask
  // Service start; the descriptor read comes last
  task automatic svc_chk(input ves_kind_t k, input logic [7:0] v,
                         input logic [23:0] ret);
    for (int i = 0; i < 300 && svc_go !== 1'b1; i++) @(negedge clk_sys);
    chk("svc_go", 1, svc_go);
    exp_rd(`VES_SC_MEM, 24'(dispatch_table_base + v * 4));
    chk("kind", k, svc_kind);
    chk("vector", v, svc_vector);
    chk("desc", {8'hC5, exp_q[$][23:0] ^ 24'h00F0F0}, svc_desc);
    chk("ret", ret, svc_ret_addr);
    cmp_rd();
  endtask
  task automatic int_case(input logic vm, su, input logic [7:0] c);
    logic [7:0] vec;
    wait_idle();
    set_psr(16'h0C02);
    cfg_vectored = vm;
    string_unfinished = su;
    ack_byte = c;
    int_pin_b = 0;
    repeat (3) @(negedge clk_sys);
    bnd_pulse();
    int_pin_b = 1;
    exp_rd(`VES_SC_ACK_M, `VES_ADR_ACK_INT);
    vec = vm ? c : `VES_VEC_NVI;
    if (vm && c >= `VES_CAS_MIN) begin
      exp_rd(`VES_SC_MEM, tab(c));
      exp_rd(`VES_SC_ACK_C, cad(c));
      vec = cas_byte;
    end else if (vm && c[7]) begin
      // Reserved negative byte: no cascade reads, default vector
      vec = `VES_VEC_NVI;
    end
    svc_chk(VES_KD_INT, vec, su ? cur_pc : next_pc);
    chk("psr_copy", su ? 16'h0802 : 16'h0C02, psr_copy);
    chk("psr_q", 16'h0000, psr_q);
    string_unfinished = 0;
  endtask
  task automatic return_from_interrupt_op_case(input logic [7:0] e);
    wait_idle();
    eoi_byte = e;
    @(negedge clk_sys);
    return_from_interrupt_op_req = 1;
    @(negedge clk_sys);
    return_from_interrupt_op_req = 0;
    wait_idle();
    exp_rd(`VES_SC_EOI_M, `VES_ADR_ACK_INT);
    if (e[7]) begin
      exp_rd(`VES_SC_MEM, tab(e));
      exp_rd(`VES_SC_EOI_C, cad(e));
    end
    cmp_rd();
  endtask
  task automatic complete_run();
    $display("TB: checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_b = 1;
    bnd_pulse();
    chk("exec_go", 1, exec_go);
    int_pin_b = 0;
    repeat (3) @(negedge clk_sys);
    bnd_pulse();
    chk("exec_go", 1, exec_go);
    cmp_rd();
    $display("TB: test boundary done");
    // Each falling edge beats a pending maskable level
    repeat (2) begin
      set_psr(16'h0800);
      nmi_pin_b = 0;
      repeat (4) @(negedge clk_sys);
      bnd_pulse();
      nmi_pin_b = 1;
      exp_rd(`VES_SC_ACK_M, `VES_ADR_ACK_NMI);
      svc_chk(VES_KD_NMI, `VES_VEC_NMI, next_pc);
      @(negedge clk_sys);
      return_from_trap_op_req = 1;
      @(negedge clk_sys);
      return_from_trap_op_req = 0;
      repeat (10) @(negedge clk_sys);
      cmp_rd();
    end
    int_pin_b = 1;
    $display("TB: test nmi done");
    // Corner bytes first, then random ones with random stalls
    for (int i = 0; i < 8; i++) begin
      lfsr_r = nxt(lfsr_r);
      slow = lfsr_r[9];
      cas_byte = lfsr_r[23:16];
      b = lfsr_r[0] ? {4'hF, lfsr_r[7:4]} : {1'b0, lfsr_r[7:1]};
      if (i < 5) b = cb[i];
      int_case(i != 0, lfsr_r[12], b);
      return_from_interrupt_op_case((i != 0 && b[7]) ? b : {1'b0, lfsr_r[30:24]});
    end
    $display("TB: test interrupts done");
    // Every trap kind, then a privileged operation in user mode
    for (int k = 0; k < 7; k++) begin
      wait_idle();
      set_psr(16'h0902);
      @(negedge clk_sys);
      inst_start = 1;
      @(negedge clk_sys);
      inst_start = 0;
      trap_kind = ves_trap_t'(k % 6);
      trap_req = (k < 6);
      priv_op = (k == 6);
      @(negedge clk_sys);
      trap_req = 0;
      priv_op = 0;
      chk("sp_restore", 1, sp_restore);
      chk("psr_q", 16'h0800, psr_q);
      svc_chk(VES_KD_TRAP, tv[k], cur_pc);
    end
    $display("TB: test traps done");
    // Trace pending at a boundary with no interrupt waiting
    wait_idle();
    set_psr(16'h0402);
    bnd_pulse();
    svc_chk(VES_KD_TRACE, `VES_VEC_TRACE, next_pc);
    chk("psr_copy", 16'h0002, psr_copy);
    chk("psr_q", 16'h0000, psr_q);
    $display("TB: test trace done");
    complete_run();
  end
  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
endmodule
